// *** rtl/stim_regs.sv ***
// sdram timing minimums, gap enforcement counters and raw/masked irq status
// assumes an apb master on pclk and a command sequencer on the same clock
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps

// Contract
// - refresh-to-refresh gap field at bits 31:27, count minus one
// - precharge to activate or refresh gap field, count minus one
// - activate to read or write gap field, count minus one
// - last write to precharge gap field, count minus one
// - activate to precharge row open time field, count minus one
// - activate to activate gap field, count minus one
// - activate to activate different bank gap field, count minus one
// - reserved bits read zero; software writes zero there
// - self-refresh exit to any command gap in its own register
// - raw timeout flag sets on timeout regardless of mask
// - timeout raised when wait stays active past the extended wait limit
// - writing one to raw timeout clears raw and masked; zero no effect
// - raw bit 2 sets on a rising edge of the wait pin
// - writing one to raw wait-rise clears raw and masked
// - raw bit 1 sets on illegal access type or bad line size
// - writing one to raw line-trap clears raw and masked
// - masked timeout setting sends a high pulse to the interrupt controller
// - masked timeout set only when enabled; raw still records
// - variants without the wait pin make irq registers reserved
module stim_regs #(
  parameter bit HAS_WAIT_PIN = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer side
  input wire stim_pkg::stim_cmd_s cmd,
  input wire logic ext_access_active,
  input wire logic line_trap_event,
  output logic [7:0] gap_busy,
  // pin and interrupt
  input wire logic memory_wait_pin,
  output logic irq_pulse
);

  // ==========================================================
  // state
  stim_pkg::stim_state_s s_q, s_d;

  localparam int NUM_GAPS_W = stim_pkg::NUM_GAPS;
  logic wr_en, rd_en, hit, wait_rise, at_event, trap_event, wr_event;
  logic [2:0] masked, w1c;
  logic [NUM_GAPS_W-1:0] gap_load;
  logic [NUM_GAPS_W-1:0][5:0] gap_val;

  // apb answers in the access cycle with no wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign hit = paddr inside {stim_pkg::OFS_SDRAM_TIMING, stim_pkg::OFS_SELF_REFRESH_EXIT,
    stim_pkg::OFS_IRQ_RAW_STATUS, stim_pkg::OFS_IRQ_MASKED_STATUS,
    stim_pkg::OFS_IRQ_MASK_ENABLE, stim_pkg::OFS_IRQ_MASK_DISABLE,
    stim_pkg::OFS_ASYNC_WAIT_CONFIG};
  assign pslverr = psel && penable && !hit;
  assign prdata = s_q.prdata;
  assign irq_pulse = s_q.irq_pulse;

  // masked view is derived, so one w1c clears raw and masked together
  assign masked = HAS_WAIT_PIN ? (s_q.irq_raw_status & s_q.irq_mask_enable) : 3'h0;
  assign w1c = (wr_en && (paddr == stim_pkg::OFS_IRQ_RAW_STATUS
    || paddr == stim_pkg::OFS_IRQ_MASKED_STATUS)) ? pwdata[2:0] : 3'h0;

  // wait edge uses the agreeing 2nd and 3rd sync stages
  assign wait_rise = s_q.wait_sync[2] && s_q.wait_sync[1] && !s_q.wait_prev;
  assign at_event = (s_q.ew_state == stim_pkg::EW_COUNT) && (s_q.ew_cnt == 8'h00)
    && s_q.wait_prev && ext_access_active;
  assign trap_event = line_trap_event;
  assign wr_event = wait_rise;

  // gap reload values per counter, field plus one
  always_comb begin
    gap_val[stim_pkg::GAP_REFRESH] = {1'b0, s_q.sdram_timing[31:27]} + 6'h01;
    gap_val[stim_pkg::GAP_PRECHARGE] = {3'h0, s_q.sdram_timing[26:24]} + 6'h01;
    gap_val[stim_pkg::GAP_ROW_TO_COL] = {3'h0, s_q.sdram_timing[22:20]} + 6'h01;
    gap_val[stim_pkg::GAP_WRITE_REC] = {3'h0, s_q.sdram_timing[18:16]} + 6'h01;
    gap_val[stim_pkg::GAP_ROW_ACTIVE] = {2'h0, s_q.sdram_timing[15:12]} + 6'h01;
    gap_val[stim_pkg::GAP_ROW_CYCLE] = {2'h0, s_q.sdram_timing[11:8]} + 6'h01;
    gap_val[stim_pkg::GAP_BANK_TO_BANK] = {3'h0, s_q.sdram_timing[6:4]} + 6'h01;
    gap_val[stim_pkg::GAP_SELF_EXIT] = {1'b0, s_q.self_refresh_exit_gap} + 6'h01;
    gap_load[stim_pkg::GAP_REFRESH] = cmd.auto_renew_cmd;
    gap_load[stim_pkg::GAP_PRECHARGE] = cmd.precharge_cmd;
    gap_load[stim_pkg::GAP_ROW_TO_COL] = cmd.row_open_cmd;
    gap_load[stim_pkg::GAP_WRITE_REC] = cmd.store_cmd;
    gap_load[stim_pkg::GAP_ROW_ACTIVE] = cmd.row_open_cmd;
    gap_load[stim_pkg::GAP_ROW_CYCLE] = cmd.row_open_cmd;
    gap_load[stim_pkg::GAP_BANK_TO_BANK] = cmd.row_open_other_bank;
    gap_load[stim_pkg::GAP_SELF_EXIT] = cmd.self_refresh_exit;
  end

  // busy while a gap counter still runs; sequencer holds dependents
  genvar g;
  generate
    for (g = 0; g < NUM_GAPS_W; g++) begin : g_busy
      assign gap_busy[g] = (s_q.gap_cnt[g] != 6'h00);
    end
  endgenerate

  // next state
  always_comb begin
    s_d = s_q;
    s_d.wait_sync = {s_q.wait_sync[1:0], memory_wait_pin};
    if (s_q.wait_sync[2] == s_q.wait_sync[1]) begin
      s_d.wait_prev = s_q.wait_sync[2];
    end
    // gap counters count down, a new command reloads
    for (int i = 0; i < NUM_GAPS_W; i++) begin
      if (gap_load[i]) begin
        s_d.gap_cnt[i] = gap_val[i];
      end else if (s_q.gap_cnt[i] != 6'h00) begin
        s_d.gap_cnt[i] = s_q.gap_cnt[i] - 6'h01;
      end
    end
    // extended wait watchdog
    case (s_q.ew_state)
      stim_pkg::EW_IDLE: begin
        if (ext_access_active && s_q.wait_prev) begin
          s_d.ew_state = stim_pkg::EW_COUNT;
          s_d.ew_cnt = s_q.extended_wait_limit;
        end
      end
      stim_pkg::EW_COUNT: begin
        if (!ext_access_active || !s_q.wait_prev) begin
          s_d.ew_state = stim_pkg::EW_IDLE;
        end else if (s_q.ew_cnt == 8'h00) begin
          s_d.ew_state = stim_pkg::EW_DONE;
        end else begin
          s_d.ew_cnt = s_q.ew_cnt - 8'h01;
        end
      end
      stim_pkg::EW_DONE: begin
        if (!ext_access_active) begin
          s_d.ew_state = stim_pkg::EW_IDLE;
        end
      end
      default: s_d.ew_state = stim_pkg::EW_IDLE;
    endcase
    // register writes
    if (wr_en) begin
      case (paddr)
        stim_pkg::OFS_SDRAM_TIMING:
          s_d.sdram_timing = pwdata & stim_pkg::SDRAM_TIMING_MASK;
        stim_pkg::OFS_SELF_REFRESH_EXIT: s_d.self_refresh_exit_gap = pwdata[4:0];
        stim_pkg::OFS_IRQ_MASK_ENABLE:
          s_d.irq_mask_enable = s_q.irq_mask_enable | pwdata[2:0];
        stim_pkg::OFS_IRQ_MASK_DISABLE:
          s_d.irq_mask_enable = s_q.irq_mask_enable & ~pwdata[2:0];
        stim_pkg::OFS_ASYNC_WAIT_CONFIG: s_d.extended_wait_limit = pwdata[7:0];
        default: ;
      endcase
    end
    // raw flags: clear by w1c, set wins over clear
    s_d.irq_raw_status = s_q.irq_raw_status & ~w1c;
    if (at_event) s_d.irq_raw_status[stim_pkg::TIMEOUT_BIT] = 1'b1;
    if (trap_event) s_d.irq_raw_status[stim_pkg::TRAP_BIT] = 1'b1;
    if (wr_event) s_d.irq_raw_status[stim_pkg::WRISE_BIT] = 1'b1;
    if (!HAS_WAIT_PIN) begin
      s_d.irq_raw_status = 3'h0;
      s_d.irq_mask_enable = 3'h0;
    end
    // one-cycle pulse on a new masked timeout
    s_d.irq_pulse = at_event && s_q.irq_mask_enable[stim_pkg::TIMEOUT_BIT] && HAS_WAIT_PIN;
    // read data captured in setup phase, reserved bits zero
    if (rd_en) begin
      case (paddr)
        stim_pkg::OFS_SDRAM_TIMING: s_d.prdata = s_q.sdram_timing;
        stim_pkg::OFS_SELF_REFRESH_EXIT: s_d.prdata = {27'h0, s_q.self_refresh_exit_gap};
        stim_pkg::OFS_IRQ_RAW_STATUS:
          s_d.prdata = HAS_WAIT_PIN ? {29'h0, s_q.irq_raw_status} : 32'h0;
        stim_pkg::OFS_IRQ_MASKED_STATUS: s_d.prdata = {29'h0, masked};
        stim_pkg::OFS_IRQ_MASK_ENABLE, stim_pkg::OFS_IRQ_MASK_DISABLE:
          s_d.prdata = {29'h0, s_q.irq_mask_enable};
        stim_pkg::OFS_ASYNC_WAIT_CONFIG: s_d.prdata = {24'h0, s_q.extended_wait_limit};
        default: s_d.prdata = 32'h0;
      endcase
    end
  end

  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.sdram_timing <= stim_pkg::SDRAM_TIMING_RST;
      s_q.self_refresh_exit_gap <= stim_pkg::SELF_REFRESH_EXIT_RST;
      s_q.extended_wait_limit <= stim_pkg::EXT_WAIT_LIMIT_RST;
      s_q.ew_state <= stim_pkg::EW_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // assertions
  a_timing_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.sdram_timing & ~stim_pkg::SDRAM_TIMING_MASK) == 32'h0)
    else $error("reserved timing bits not zero");

  a_refresh_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.auto_renew_cmd |=> s_q.gap_cnt[0] == {1'b0, $past(s_q.sdram_timing[31:27])} + 6'h01)
    else $error("refresh gap not loaded with field plus one");

  a_gap_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd.row_open_cmd && s_q.sdram_timing[22:20] == 3'h2 && !$past(cmd.row_open_cmd))
    |=> gap_busy[2] [*3] ##1 (gap_busy[2] == 1'b0 || cmd.row_open_cmd || $past(cmd.row_open_cmd)))
    else $error("row to column gap length wrong");

  a_exit_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.self_refresh_exit |=> s_q.gap_cnt[7] == {1'b0, $past(s_q.self_refresh_exit_gap)} + 6'h01)
    else $error("self refresh exit gap wrong");

  a_at_raw_set: assert property (@(posedge pclk) disable iff (!presetn)
    (at_event && HAS_WAIT_PIN) |=> s_q.irq_raw_status[0])
    else $error("timeout did not set raw flag");

  a_trap_raw_set: assert property (@(posedge pclk) disable iff (!presetn)
    (line_trap_event && HAS_WAIT_PIN) |=> s_q.irq_raw_status[1])
    else $error("line trap did not set raw flag");

  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (w1c[0] && !at_event) |=> !s_q.irq_raw_status[0] && !masked[0])
    else $error("timeout flag not cleared by one");

  a_w1c_zero_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.irq_raw_status[2] && !w1c[2]) |=> s_q.irq_raw_status[2])
    else $error("wait rise flag lost without a one write");

  a_masked_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.irq_mask_enable[0] |-> !masked[0])
    else $error("masked timeout set while disabled");

  a_irq_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    irq_pulse |-> masked[0] ##1 !irq_pulse || $past(at_event))
    else $error("interrupt pulse without masked timeout");

  // ==========================================================
  // per-gap reload checks, one per timing field
  a_precharge_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.precharge_cmd |=> s_q.gap_cnt[1] == {3'h0, $past(s_q.sdram_timing[26:24])} + 6'h01)
    else $error("precharge gap not loaded with field plus one");

  a_row_col_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.row_open_cmd |=> s_q.gap_cnt[2] == {3'h0, $past(s_q.sdram_timing[22:20])} + 6'h01)
    else $error("row to column gap not loaded with field plus one");

  a_write_rec_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.store_cmd |=> s_q.gap_cnt[3] == {3'h0, $past(s_q.sdram_timing[18:16])} + 6'h01)
    else $error("write recovery gap not loaded with field plus one");

  a_row_active_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.row_open_cmd |=> s_q.gap_cnt[4] == {2'h0, $past(s_q.sdram_timing[15:12])} + 6'h01)
    else $error("row active gap not loaded with field plus one");

  a_row_cycle_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.row_open_cmd |=> s_q.gap_cnt[5] == {2'h0, $past(s_q.sdram_timing[11:8])} + 6'h01)
    else $error("row cycle gap not loaded with field plus one");

  a_bank_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.row_open_other_bank |=> s_q.gap_cnt[6] == {3'h0, $past(s_q.sdram_timing[6:4])} + 6'h01)
    else $error("bank to bank gap not loaded with field plus one");

  // a running counter drops by exactly one per cycle until a reload
  a_gap_count_down: assert property (@(posedge pclk) disable iff (!presetn)
    (!gap_load[0] && s_q.gap_cnt[0] != 6'h00) |=> s_q.gap_cnt[0] == $past(s_q.gap_cnt[0]) - 6'h01)
    else $error("refresh gap counter did not step down");

  // ==========================================================
  // watchdog steps: waiting with the count spent must end in done
  sequence s_wait_spent;
    s_q.ew_state == stim_pkg::EW_COUNT && s_q.ew_cnt == 8'h00;
  endsequence

  sequence s_still_waiting;
    s_q.wait_prev && ext_access_active;
  endsequence

  a_timeout_raise: assert property (@(posedge pclk) disable iff (!presetn)
    (s_wait_spent and s_still_waiting) |=> s_q.ew_state == stim_pkg::EW_DONE)
    else $error("extended wait limit passed without timeout");

  // ==========================================================
  // flag set and clear checks
  a_wrise_raw_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wait_rise && HAS_WAIT_PIN) |=> s_q.irq_raw_status[2])
    else $error("wait rise did not set raw flag");

  a_wrise_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (w1c[2] && !wait_rise) |=> !s_q.irq_raw_status[2] && !masked[2])
    else $error("wait rise flag not cleared by one");

  a_trap_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (w1c[1] && !trap_event) |=> !s_q.irq_raw_status[1] && !masked[1])
    else $error("line trap flag not cleared by one");

  a_timeout_zero_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.irq_raw_status[0] && !w1c[0]) |=> s_q.irq_raw_status[0])
    else $error("timeout flag lost without a one write");

  a_no_pin_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_WAIT_PIN |-> (s_q.irq_raw_status == 3'h0 && masked == 3'h0))
    else $error("irq flags live on a variant without wait pin");

  // status read data keeps the reserved upper bits at zero
  a_status_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(rd_en) && $past(paddr) == stim_pkg::OFS_IRQ_RAW_STATUS) |-> prdata[31:3] == 29'h0)
    else $error("raw status read shows reserved bits");

  // the watchdog leaves count at once, so the pulse never doubles
  a_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
    irq_pulse |=> !irq_pulse)
    else $error("interrupt pulse longer than one cycle");

endmodule : stim_regs

// *** include/stim_pkg.sv ***
// constants, register map and state layout for the sdram timing and irq status block
// assumes an apb slave with 32-bit data on a single clock
package stim_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_SDRAM_TIMING = 8'h00;
  localparam logic [7:0] OFS_SELF_REFRESH_EXIT = 8'h04;
  localparam logic [7:0] OFS_IRQ_RAW_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASKED_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK_ENABLE = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK_DISABLE = 8'h14;
  localparam logic [7:0] OFS_ASYNC_WAIT_CONFIG = 8'h18;

  // ==========================================================
  // field positions
  localparam int RFC_LSB = 27;
  localparam int RP_LSB = 24;
  localparam int RCD_LSB = 20;
  localparam int WR_LSB = 16;
  localparam int RAS_LSB = 12;
  localparam int RC_LSB = 8;
  localparam int RRD_LSB = 4;
  localparam int XS_LSB = 0;
  localparam int TIMEOUT_BIT = 0;
  localparam int TRAP_BIT = 1;
  localparam int WRISE_BIT = 2;

  // ==========================================================
  // reset values and writable masks
  localparam logic [31:0] SDRAM_TIMING_RST = 32'h4221_5810;
  localparam logic [31:0] SDRAM_TIMING_MASK = 32'hff77_ff70;
  localparam logic [4:0] SELF_REFRESH_EXIT_RST = 5'h09;
  localparam logic [7:0] EXT_WAIT_LIMIT_RST = 8'h80;
  localparam logic [2:0] IRQ_BITS_MASK = 3'h7;

  // ==========================================================
  // gap selectors for the sequencer-side counters
  typedef enum logic [2:0] {
    GAP_REFRESH, GAP_PRECHARGE, GAP_ROW_TO_COL, GAP_WRITE_REC,
    GAP_ROW_ACTIVE, GAP_ROW_CYCLE, GAP_BANK_TO_BANK, GAP_SELF_EXIT
  } stim_gap_e;
  localparam int NUM_GAPS = 8;

  typedef enum logic [1:0] {EW_IDLE, EW_COUNT, EW_DONE} stim_ew_e;

  // sequencer command strobes
  typedef struct packed {
    logic auto_renew_cmd;
    logic precharge_cmd;
    logic row_open_cmd;
    logic read_cmd;
    logic store_cmd;
    logic row_open_other_bank;
    logic self_refresh_exit;
  } stim_cmd_s;

  // whole state of the block
  typedef struct packed {
    logic [31:0] sdram_timing;
    logic [4:0] self_refresh_exit_gap;
    logic [2:0] irq_raw_status;
    logic [2:0] irq_mask_enable;
    logic [7:0] extended_wait_limit;
    logic [31:0] prdata;
    logic [NUM_GAPS-1:0][5:0] gap_cnt;
    stim_ew_e ew_state;
    logic [7:0] ew_cnt;
    logic [2:0] wait_sync;
    logic wait_prev;
    logic irq_pulse;
  } stim_state_s;

endpackage : stim_pkg

// *** test/stim_mem_model.sv ***
// far-side memory model: one extended access with the wait pin held a given time
// assumes the bench pulses go for one cycle and waits for done
`timescale 1ns/10ps
module stim_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic go,
  input wire logic [7:0] wait_len,
  // memory side
  output logic ext_access_active,
  output logic memory_wait_pin,
  output logic done
);
  // ==========================================================
  // access sequencing
  logic [7:0] cnt_q;
  // wait is released before the access closes, so a long hold can time out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_access_active <= 1'b0;
      memory_wait_pin <= 1'b0;
      cnt_q <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go && !ext_access_active) begin
        ext_access_active <= 1'b1;
        memory_wait_pin <= 1'b1;
        cnt_q <= wait_len;
      end else if (ext_access_active && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (ext_access_active && memory_wait_pin) begin
        memory_wait_pin <= 1'b0; // idle level is wait inactive
      end else if (ext_access_active) begin
        ext_access_active <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : stim_mem_model

// *** test/stim_regs_tb.sv ***
// self-checking bench for the timing and irq status registers
// assumes zero-wait apb and the memory model on the wait pin
`timescale 1ns/10ps
module stim_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_trap_event;
  logic [7:0] paddr, gap_busy, wait_len;
  logic [31:0] pwdata, prdata, r;
  logic e, go, ext_access_active, memory_wait_pin, done, irq_pulse;
  stim_pkg::stim_cmd_s cmd;
  int n_fail, cmp_count, n_irq;
  int cb[8] = '{6, 5, 4, 2, 4, 4, 1, 0};
  int ex[8] = '{6, 7, 4, 5, 11, 13, 3, 14};

  stim_regs stim_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .ext_access_active(ext_access_active),
    .line_trap_event(line_trap_event), .gap_busy(gap_busy),
    .memory_wait_pin(memory_wait_pin), .irq_pulse(irq_pulse));
  stim_mem_model stim_mem_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .wait_len(wait_len), .ext_access_active(ext_access_active),
    .memory_wait_pin(memory_wait_pin), .done(done));

  // ==========================================================
  // clock and pulse counter
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // counted at the edge so a one-cycle pulse is never missed
  always @(posedge pclk) if (irq_pulse === 1'b1) n_irq++;

  // ==========================================================
  // shared tasks
  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) begin
      n_fail++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask : rd
  task access(input logic [7:0] len);
    int n;
    go <= 1'b1; wait_len <= len;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 200) begin
      n_fail++;
      final_report();
    end
    repeat (10) @(posedge pclk); // let the pin synchroniser settle
  endtask : access
  task gap(input int i);
    int n;
    cmd <= stim_pkg::stim_cmd_s'(7'h01 << cb[i]);
    @(posedge pclk);
    cmd <= '0;
    n = 0;
    @(negedge pclk);
    while (gap_busy[i] === 1'b1 && n < 100) begin
      n++;
      @(negedge pclk);
    end
    chk(32'(n), 32'(ex[i]));
    repeat (20) @(posedge pclk);
  endtask : gap

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; cmd = '0; line_trap_event = 1'b0; go = 1'b0; wait_len = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h4221_5810);
    rd(8'h04, 32'h0000_0009);
    rd(8'h08, 32'h0000_0000);
    $display("test reset values done");
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rd(8'h00, stim_pkg::SDRAM_TIMING_MASK);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0000_001f);
    rd(8'h20, 32'h0000_0000);
    chk({31'h0, e}, 32'h1);
    $display("test reserved bits done");
    apb(1'b1, 8'h00, 32'h2e34_ac20);
    apb(1'b1, 8'h04, 32'h0000_000d);
    for (int i = 0; i < 8; i++) gap(i);
    $display("test gap counters done");
    line_trap_event <= 1'b1;
    @(posedge pclk);
    line_trap_event <= 1'b0;
    @(posedge pclk);
    rd(8'h08, 32'h0000_0002);
    apb(1'b1, 8'h08, 32'h0000_0000);
    rd(8'h08, 32'h0000_0002);
    apb(1'b1, 8'h10, 32'h0000_0002);
    rd(8'h0c, 32'h0000_0002);
    apb(1'b1, 8'h08, 32'h0000_0002);
    rd(8'h0c, 32'h0000_0000);
    $display("test line trap done");
    apb(1'b1, 8'h18, 32'h0000_0008);
    apb(1'b1, 8'h14, 32'h0000_0007);
    access(8'h04);
    rd(8'h08, 32'h0000_0004);
    apb(1'b1, 8'h0c, 32'h0000_0004);
    rd(8'h08, 32'h0000_0000);
    access(8'h28);
    rd(8'h08, 32'h0000_0005);
    rd(8'h0c, 32'h0000_0000);
    chk(32'(n_irq), 32'h0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    rd(8'h08, 32'h0000_0004);
    apb(1'b1, 8'h10, 32'h0000_0001);
    access(8'h28);
    rd(8'h0c, 32'h0000_0001);
    chk(32'(n_irq), 32'h1);
    apb(1'b1, 8'h0c, 32'h0000_0001);
    rd(8'h08, 32'h0000_0004);
    $display("test timeout and wait rise done");
    final_report();
  end
endmodule : stim_regs_tb
